// ===== shared/fwe_fifo_if.sv
// valid/ready carrier between the engine and its output fifo
`timescale 1ns/100ps
interface fwe_fifo_if #(parameter int W = 8) (
  input wire logic clk,
  input wire logic rst_n
);
  logic in_valid; // fill side word offered
  logic in_ready; // fifo has room
  logic [W-1:0] in_data; // fill side word
  logic out_valid; // fifo not empty
  logic out_ready; // drain side takes a word
  logic [W-1:0] out_data; // oldest word
  modport feeder (input clk, input rst_n, output in_valid, output in_data, input in_ready,
    input out_valid, input out_data, output out_ready);
  modport store (input clk, input rst_n, input in_valid, input in_data, output in_ready,
    output out_valid, output out_data, input out_ready);
endinterface

// ===== shared/fwe_pkg.sv
// constants and types shared by the forwarding engine design
package fwe_pkg;
  // register byte offsets on the serial control bus
  localparam logic [7:0] ADR_FWD_PORT = 8'h20; // forward_port_control
  localparam logic [7:0] ADR_FWD_MODE = 8'h21; // forward_mode_control
  localparam logic [7:0] ADR_TX_CTL = 8'h33; // transmitter_control
  localparam logic [7:0] ADR_TX_STATUS = 8'h35; // transmitter status, read only
  // reset values
  localparam logic [7:0] RST_FWD_PORT = 8'h30; // both ports disabled
  localparam logic [7:0] RST_FWD_MODE = 8'h01; // round robin on, sync off
  localparam logic [7:0] RST_TX_CTL = 8'h00; // transmitter off
  // field positions
  localparam int PORT_DIS_LSB = 4; // port_forward_disable, one bit per port
  localparam int RR_BIT = 0; // round_robin_enable
  localparam int SYNC_LSB = 2; // sync_forward_select, two bits
  localparam int TX_EN_BIT = 0; // transmitter enable
  localparam int TX_CONT_BIT = 1; // continuous clock
  localparam int STS_SYNC_BIT = 0; // live synchronized status
  localparam int STS_LOST_BIT = 1; // sticky sync lost
  localparam int STS_HS_BIT = 2; // high speed burst active
  // sizes and defaults
  localparam int NUM_PORTS = 2; // receive ports feeding the engine
  localparam int DATA_W_DEF = 32; // buffer word width
  localparam int FIFO_DEPTH_DEF = 32; // words of output fifo
  localparam logic [6:0] I2C_ADDR_DEF = 7'h30; // local slave address
  // synchronized forwarding options
  typedef enum logic [1:0] {SYNC_OFF, SYNC_BASIC, SYNC_INTERLEAVE, SYNC_CONCAT} fwe_sync_t;
  // packet kind flagged on a packet's first word
  typedef enum logic [1:0] {KIND_LINE, KIND_FS, KIND_FE, KIND_OTHER} fwe_kind_t;
  // engine states
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_DROP} fwe_state_t;
  // serial slave states
  typedef enum logic [1:0] {I2C_IDLE, I2C_RECV, I2C_SEND} fwe_i2c_t;
endpackage

// ===== src/fwe_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
module fwe_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  fwe_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);
  // refuse depths the pointer scheme cannot serve
  if (DEPTH < 2 || (2 ** AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end
  logic [W-1:0] mem [DEPTH]; // storage words
  logic [AW:0] wr_ptr_ff; // write pointer with wrap bit
  logic [AW:0] rd_ptr_ff; // read pointer with wrap bit
  wire push = q.in_valid & q.in_ready;
  wire pop = q.out_valid & q.out_ready;
  // full when wrap bits differ and indexes meet
  wire full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire empty = (wr_ptr_ff == rd_ptr_ff);
  assign q.in_ready = !full;
  assign q.out_valid = !empty;
  assign q.out_data = mem[rd_ptr_ff[AW-1:0]];
  // pointer update
  always_ff @(posedge q.clk or negedge q.rst_n) begin
    if (!q.rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
  // storage write, no reset needed
  always_ff @(posedge q.clk) begin
    if (push) mem[wr_ptr_ff[AW-1:0]] <= q.in_data;
  end
endmodule

// ===== src/fwe_forward_engine.sv
// forwarding engine from two receive buffers to the camera serial transmitter
// Function
// - move buffered packets out, make lp/hs transitions
// - watch each buffer for packet availability
// - per port disable stops that port forwarding
// - one buffer serves one transmitter, engines independent
// - enabled transmitter rests in lp11 stop state
// - best effort sends available packets, round robin
// - best effort: no ordering, frame packets per channel
// - round robin active when its bit set
// - synchronized: port0 then port1, packets and lines
// - sync failure: discard, resume at frame start
// - live sync status, sticky lost flag cleared by read
// - sync field picks basic, interleave or concatenated; concatenated is forwarded as basic
// - basic: whole frames, ends ordered A then B
// - basic: packets carry their port's mapped channel
// - interleave: one start and end, all lines sent
// - pull only when a whole packet is buffered
// - sync status reads zero while sync disabled
`timescale 1ns/100ps
module fwe_forward_engine #(
  parameter logic [6:0] I2C_ADDR = fwe_pkg::I2C_ADDR_DEF,
  parameter int DATA_W = fwe_pkg::DATA_W_DEF,
  parameter int FIFO_DEPTH = fwe_pkg::FIFO_DEPTH_DEF
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [fwe_pkg::NUM_PORTS-1:0] buf_pkt_avail,
  input wire logic [fwe_pkg::NUM_PORTS-1:0] buf_valid,
  input wire logic [fwe_pkg::NUM_PORTS-1:0][DATA_W-1:0] buf_data,
  input wire logic [fwe_pkg::NUM_PORTS-1:0] buf_last,
  input wire logic [fwe_pkg::NUM_PORTS-1:0][1:0] buf_kind,
  input wire logic [fwe_pkg::NUM_PORTS-1:0][1:0] buf_vc,
  output logic [fwe_pkg::NUM_PORTS-1:0] buf_ready,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [DATA_W-1:0] tx_data,
  output logic [1:0] tx_vc,
  output logic tx_last,
  output logic tx_hs_active,
  output logic tx_lp11,
  output logic tx_clk_continuous
);
  localparam int PAY_W = DATA_W + 3; // last, channel, data
  // the turn logic is written for exactly two ports
  if (fwe_pkg::NUM_PORTS != 2 || DATA_W < 8) begin : g_bad_cfg
    $error("engine supports two ports and data width of at least 8");
  end

  // next port after cur that the mask allows, else cur
  function automatic logic fwe_after(input logic cur, input logic [1:0] mask);
    fwe_after = mask[~cur] ? ~cur : cur;
  endfunction

  // reset release through two flops
  logic rst_meta_ff; // first stage
  logic rst_n; // released reset copy
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // ---------------- serial control slave ----------------
  logic scl_meta_ff; // scl first stage
  logic scl_ff; // scl synchronised
  logic sda_meta_ff; // sda first stage
  logic sda_ff; // sda synchronised
  logic scl_old_ff; // scl one sample back
  logic sda_old_ff; // sda one sample back
  // pin synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta_ff <= 1'b1;
      scl_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_ff <= 1'b1;
      scl_old_ff <= 1'b1;
      sda_old_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl;
      scl_ff <= scl_meta_ff;
      sda_meta_ff <= sda_in;
      sda_ff <= sda_meta_ff;
      scl_old_ff <= scl_ff;
      sda_old_ff <= sda_ff;
    end
  end
  // bus events
  wire scl_rise = scl_ff & ~scl_old_ff;
  wire scl_fall = ~scl_ff & scl_old_ff;
  wire bus_start = scl_ff & scl_old_ff & sda_old_ff & ~sda_ff;
  wire bus_stop = scl_ff & scl_old_ff & ~sda_old_ff & sda_ff;

  fwe_pkg::fwe_i2c_t i2c_ff; // slave state
  logic [3:0] bitcnt_ff; // clock rises in this byte
  logic [7:0] sh_ff; // byte shift register
  logic [7:0] ptr_ff; // register pointer
  logic addr_ph_ff; // next byte is the address
  logic ptr_set_ff; // pointer byte received
  logic rd_ff; // read transfer
  logic mack_ff; // master acknowledged last byte
  logic drive_ff; // pulling sda low
  logic [7:0] fwd_port_ff; // forward_port_control
  logic [7:0] fwd_mode_ff; // forward_mode_control
  logic [7:0] tx_ctl_ff; // transmitter_control
  logic [7:0] sts_word; // status read value
  logic [7:0] rdata; // register read value

  // byte completion decodes
  wire byte_end = scl_fall && (bitcnt_ff == 4'h8);
  wire ack_end = scl_fall && (bitcnt_ff == 4'h9);
  wire addr_hit = (sh_ff[7:1] == I2C_ADDR);
  wire wr_now = byte_end && (i2c_ff == fwe_pkg::I2C_RECV) && !addr_ph_ff && ptr_set_ff;
  wire load_now = ack_end && rd_ff && (i2c_ff == fwe_pkg::I2C_SEND ? mack_ff :
    i2c_ff == fwe_pkg::I2C_RECV);
  wire rd_clr_lost = load_now && (ptr_ff == fwe_pkg::ADR_TX_STATUS);
  // read mux, unmapped offsets read zero
  assign rdata = (ptr_ff == fwe_pkg::ADR_FWD_PORT) ? fwd_port_ff :
                 (ptr_ff == fwe_pkg::ADR_FWD_MODE) ? fwd_mode_ff :
                 (ptr_ff == fwe_pkg::ADR_TX_CTL) ? tx_ctl_ff :
                 (ptr_ff == fwe_pkg::ADR_TX_STATUS) ? sts_word : 8'h00;
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_ff;

  // slave sequencing on synchronised bus events
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      i2c_ff <= fwe_pkg::I2C_IDLE;
      bitcnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      addr_ph_ff <= 1'b0;
      ptr_set_ff <= 1'b0;
      rd_ff <= 1'b0;
      mack_ff <= 1'b0;
      drive_ff <= 1'b0;
    end else if (bus_start) begin
      i2c_ff <= fwe_pkg::I2C_RECV;
      bitcnt_ff <= 4'h0;
      addr_ph_ff <= 1'b1;
      ptr_set_ff <= 1'b0;
      drive_ff <= 1'b0;
    end else if (bus_stop || i2c_ff == fwe_pkg::I2C_IDLE) begin
      i2c_ff <= fwe_pkg::I2C_IDLE;
      drive_ff <= 1'b0;
    end else if (scl_rise) begin
      // sample data or the master's acknowledge
      bitcnt_ff <= bitcnt_ff + 4'h1;
      if (i2c_ff == fwe_pkg::I2C_RECV && bitcnt_ff < 4'h8) sh_ff <= {sh_ff[6:0], sda_ff};
      if (bitcnt_ff == 4'h8) mack_ff <= ~sda_ff;
    end else if (byte_end) begin
      // byte done: acknowledge or release for the master
      drive_ff <= (i2c_ff == fwe_pkg::I2C_RECV) && (!addr_ph_ff || addr_hit);
      if (i2c_ff == fwe_pkg::I2C_RECV && addr_ph_ff) begin
        if (!addr_hit) i2c_ff <= fwe_pkg::I2C_IDLE;
        rd_ff <= sh_ff[0];
        addr_ph_ff <= 1'b0;
      end else if (i2c_ff == fwe_pkg::I2C_RECV && !ptr_set_ff) begin
        ptr_ff <= sh_ff;
        ptr_set_ff <= 1'b1;
      end else if (i2c_ff == fwe_pkg::I2C_RECV) begin
        ptr_ff <= ptr_ff + 8'h01;
      end
    end else if (ack_end) begin
      // start next byte: load read data or release
      bitcnt_ff <= 4'h0;
      if (load_now) begin
        i2c_ff <= fwe_pkg::I2C_SEND;
        sh_ff <= rdata;
        drive_ff <= ~rdata[7];
        ptr_ff <= ptr_ff + 8'h01;
      end else begin
        if (i2c_ff == fwe_pkg::I2C_SEND) i2c_ff <= fwe_pkg::I2C_IDLE;
        drive_ff <= 1'b0;
      end
    end else if (scl_fall && i2c_ff == fwe_pkg::I2C_SEND && bitcnt_ff < 4'h8) begin
      // shift out next read bit, msb first
      sh_ff <= {sh_ff[6:0], 1'b0};
      drive_ff <= ~sh_ff[6];
    end
  end

  // control registers written from the bus
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_port_ff <= fwe_pkg::RST_FWD_PORT;
      fwd_mode_ff <= fwe_pkg::RST_FWD_MODE;
      tx_ctl_ff <= fwe_pkg::RST_TX_CTL;
    end else if (wr_now) begin
      if (ptr_ff == fwe_pkg::ADR_FWD_PORT) fwd_port_ff <= sh_ff;
      if (ptr_ff == fwe_pkg::ADR_FWD_MODE) fwd_mode_ff <= sh_ff;
      if (ptr_ff == fwe_pkg::ADR_TX_CTL) tx_ctl_ff <= sh_ff;
    end
  end

  // ---------------- forwarding decisions ----------------
  fwe_pkg::fwe_state_t state_ff; // engine state
  logic sel_ff; // port being moved
  logic rr_last_ff; // last port served in round robin
  logic turn_ff; // port whose packet is due in sync mode
  logic synced_ff; // sources locked together
  logic [1:0] pair_kind_ff; // kind sent by port0 this pair
  logic adv_ff; // advance turn when packet ends
  logic lost_ff; // sticky sync lost
  logic hs_ff; // high speed burst in progress
  fwe_fifo_if #(.W(PAY_W)) fq (.clk(mclk), .rst_n(rst_n));

  wire [1:0] port_dis = fwd_port_ff[fwe_pkg::PORT_DIS_LSB +: 2];
  wire [1:0] en_mask = ~port_dis;
  wire both_en = &en_mask;
  wire rr_en = fwd_mode_ff[fwe_pkg::RR_BIT];
  wire [1:0] sync_mode = fwd_mode_ff[fwe_pkg::SYNC_LSB +: 2];
  wire sync_en = (sync_mode != fwe_pkg::SYNC_OFF);
  wire tx_en = tx_ctl_ff[fwe_pkg::TX_EN_BIT];
  wire sync_status = sync_en & synced_ff;
  // candidates: whole packet buffered and port enabled
  wire [1:0] ready_p = buf_pkt_avail & en_mask;
  wire [1:0] head_fs = {ready_p[1] && buf_kind[1] == fwe_pkg::KIND_FS,
                        ready_p[0] && buf_kind[0] == fwe_pkg::KIND_FS};
  wire all_fs = (&(head_fs | ~en_mask)) && (|en_mask);
  wire [1:0] junk = ready_p & ~head_fs; // packets discarded while unlocked
  wire junk_sel = ~junk[0];
  wire pick_rr = fwe_after(rr_last_ff, ready_p);
  wire second = both_en && turn_ff; // port1 closes the pair
  wire mismatch = second && (buf_kind[1] != pair_kind_ff);
  wire kind_sync = (buf_kind[turn_ff] == fwe_pkg::KIND_FS) ||
                   (buf_kind[turn_ff] == fwe_pkg::KIND_FE);
  wire dup_sync = second && (sync_mode == fwe_pkg::SYNC_INTERLEAVE) && kind_sync;
  wire in_idle = (state_ff == fwe_pkg::ST_IDLE) && tx_en;
  wire go_rr = in_idle && !sync_en && rr_en && (|ready_p);
  wire go_sync = in_idle && sync_en && !synced_ff && all_fs;
  wire go_junk = in_idle && sync_en && !synced_ff && !all_fs && (|junk);
  wire go_turn = in_idle && sync_en && synced_ff && ready_p[turn_ff];
  wire sync_fail = go_turn && mismatch;
  wire go_send = go_rr || (go_turn && !mismatch && !dup_sync);
  wire go_drop = go_junk || (go_turn && (mismatch || dup_sync));
  // a buffer is only ever read by this one engine
  wire go_sel = go_rr ? pick_rr : (go_junk ? junk_sel : turn_ff);
  wire moving = (state_ff != fwe_pkg::ST_IDLE);
  wire take = moving && buf_valid[sel_ff] && buf_ready[sel_ff];
  wire end_pkt = take && buf_last[sel_ff];

  // pop the chosen buffer; sending stalls on a full fifo
  assign buf_ready[0] = moving && !sel_ff && (state_ff == fwe_pkg::ST_DROP || fq.in_ready);
  assign buf_ready[1] = moving && sel_ff && (state_ff == fwe_pkg::ST_DROP || fq.in_ready);
  // channel travels with the packet as mapped for its port
  assign fq.in_valid = (state_ff == fwe_pkg::ST_SEND) && buf_valid[sel_ff];
  assign fq.in_data = {buf_last[sel_ff], buf_vc[sel_ff], buf_data[sel_ff]};

  // engine state and selection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= fwe_pkg::ST_IDLE;
      sel_ff <= 1'b0;
      adv_ff <= 1'b0;
    end else begin
      case (state_ff)
        fwe_pkg::ST_IDLE: begin
          sel_ff <= go_sel;
          adv_ff <= go_turn && !mismatch;
          if (go_send) state_ff <= fwe_pkg::ST_SEND;
          else if (go_drop) state_ff <= fwe_pkg::ST_DROP;
        end
        fwe_pkg::ST_SEND, fwe_pkg::ST_DROP: begin
          if (end_pkt) state_ff <= fwe_pkg::ST_IDLE;
        end
        default: state_ff <= fwe_pkg::ST_IDLE;
      endcase
    end
  end

  // round robin pointer, sync turn and lock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rr_last_ff <= 1'b1;
      turn_ff <= 1'b0;
      synced_ff <= 1'b0;
      pair_kind_ff <= fwe_pkg::KIND_LINE;
    end else begin
      if (end_pkt && state_ff == fwe_pkg::ST_SEND) rr_last_ff <= sel_ff;
      if (!sync_en || sync_fail) synced_ff <= 1'b0;
      else if (go_sync) synced_ff <= 1'b1;
      if (go_sync) turn_ff <= ~en_mask[0];
      else if (end_pkt && adv_ff) turn_ff <= fwe_after(sel_ff, en_mask);
      if (go_turn && !turn_ff) pair_kind_ff <= buf_kind[0];
    end
  end

  // sticky lost flag, a new loss beats the read clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) lost_ff <= 1'b0;
    else lost_ff <= sync_fail | (lost_ff & ~rd_clr_lost);
  end

  always_comb begin
    sts_word = 8'h00;
    sts_word[fwe_pkg::STS_SYNC_BIT] = sync_status;
    sts_word[fwe_pkg::STS_LOST_BIT] = lost_ff;
    sts_word[fwe_pkg::STS_HS_BIT] = hs_ff;
  end

  // output fifo between engine and transmitter
  fwe_fifo #(.W(PAY_W), .DEPTH(FIFO_DEPTH)) u_fifo (.q(fq.store));

  // ---------------- transmitter side ----------------
  wire tx_take = tx_valid && tx_ready;
  // one burst per packet: lp11 to hs when data waits, back at packet end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) hs_ff <= 1'b0;
    else if (!tx_en) hs_ff <= 1'b0;
    else if (!hs_ff && fq.out_valid) hs_ff <= 1'b1;
    else if (tx_take && tx_last) hs_ff <= 1'b0;
  end
  assign fq.out_ready = hs_ff && tx_ready;
  assign tx_valid = hs_ff && fq.out_valid;
  assign tx_data = fq.out_data[DATA_W-1:0];
  assign tx_vc = fq.out_data[DATA_W +: 2];
  assign tx_last = fq.out_data[PAY_W-1];
  assign tx_hs_active = hs_ff;
  assign tx_lp11 = tx_en && !hs_ff;
  assign tx_clk_continuous = tx_en && tx_ctl_ff[fwe_pkg::TX_CONT_BIT];

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_sync_off_zero: assert property (!sync_en |-> !sts_word[fwe_pkg::STS_SYNC_BIT])
    else $error("sync status set while sync forwarding off");
  chk_lost_sticky: assert property (sync_fail |=> lost_ff ##1 (lost_ff || $past(rd_clr_lost)))
    else $error("sync lost flag not held");
  chk_whole_packet: assert property ((go_send || go_drop) |-> buf_pkt_avail[go_sel])
    else $error("packet started before fully buffered");
  chk_port_disabled: assert property ((go_send || go_drop) |-> !port_dis[go_sel])
    else $error("disabled port selected");
  chk_rr_fair: assert property ((go_rr && &ready_p) |-> go_sel != rr_last_ff)
    else $error("round robin served same port twice");
  chk_rr_needs_bit: assert property ((!rr_en && !sync_en) |-> !(go_send || go_drop))
    else $error("forwarding with no mode enabled");
  chk_drop_mute: assert property (state_ff == fwe_pkg::ST_DROP |-> !fq.in_valid)
    else $error("dropped packet reached fifo");
  chk_interleave_drop: assert property ((go_turn && dup_sync) |=> state_ff == fwe_pkg::ST_DROP)
    else $error("duplicate frame packet not dropped");
  chk_pair_order: assert property ((end_pkt && adv_ff && sel_ff && both_en) |=> !turn_ff)
    else $error("port1 not followed by port0");
  chk_lp11_idle: assert property ((tx_en && !hs_ff && !fq.out_valid) |=> !hs_ff)
    else $error("idle transmitter not in stop state");
  chk_burst_start: assert property ((tx_en && !hs_ff && fq.out_valid) |=> hs_ff ##[0:2] hs_ff)
    else $error("no burst for waiting data");
  cov_lock: cover property (go_sync ##[1:200] go_turn);
  cov_fail: cover property (sync_fail);
  cov_rr_both: cover property (go_rr && &ready_p);
  cov_burst: cover property (tx_take && tx_last);
endmodule

// ===== tb/fwe_rx_model.sv
// downstream receiver model: stalls at random and logs each packet's channel
`timescale 1ns/100ps
module fwe_rx_model (
  input wire logic mclk,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic [1:0] tx_vc,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [1:0] vc_log[$]; // channel of each finished packet
  logic [2:0] pk_log[$]; // kind and source port from each packet's last word
  initial tx_ready = 1'b0;
  // accept on valid and ready, stall about one cycle in four
  always @(posedge mclk) begin
    if (tx_valid && tx_ready && tx_last) begin
      vc_log.push_back(tx_vc);
      pk_log.push_back(tx_data[5:3]);
    end
    tx_ready <= #1 (($urandom % 4) != 0);
  end
endmodule

// ===== tb/tb.sv
// self-checking bench for the forwarding engine
`timescale 1ns/100ps
module tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic scl = 1'b1; // serial control clock, master side
  logic sda_m = 1'b1; // master data drive, 1 = released
  logic src_on = 1'b0; // sources offer packets
  logic [1:0] avail, bvalid, last, ready;
  logic [1:0][31:0] bdata;
  logic [1:0][1:0] kind, vc;
  logic [1:0][2:0] w = '0; // word index per port
  logic [1:0][2:0] ln = '0; // last word index per port
  logic [1:0][2:0] pk = '0; // packet position within the frame per port
  logic [2:0] k1_off = 3'h0; // shifts port1 framing to force a loss
  logic same_vc = 1'b0; // every source on channel 0
  int n1 = 0; // port1 packets seen in interleave
  logic tx_valid, tx_ready, tx_last, hs, lp11, cont, sda_out, sda_oe_n;
  logic [31:0] tx_data;
  logic [1:0] tx_vc;
  logic [8:0] r; // bits seen on the line
  logic [7:0] v;
  logic [7:0] adr[4] = '{fwe_pkg::ADR_FWD_PORT, fwe_pkg::ADR_FWD_MODE,
    fwe_pkg::ADR_TX_CTL, 8'h40};
  logic [7:0] rst[4] = '{fwe_pkg::RST_FWD_PORT, fwe_pkg::RST_FWD_MODE,
    fwe_pkg::RST_TX_CTL, 8'h00};
  int fails = 0;
  int samples_checked = 0;
  wire logic sda = sda_m & sda_oe_n; // pulled-up open drain line
  always #25 mclk = ~mclk;
  fwe_forward_engine dut_u (.mclk(mclk), .resetn(resetn), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .buf_pkt_avail(avail), .buf_valid(bvalid),
    .buf_data(bdata), .buf_last(last), .buf_kind(kind), .buf_vc(vc), .buf_ready(ready),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_vc(tx_vc),
    .tx_last(tx_last), .tx_hs_active(hs), .tx_lp11(lp11), .tx_clk_continuous(cont));
  fwe_rx_model rx_u (.mclk(mclk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_vc(tx_vc),
    .tx_last(tx_last), .tx_ready(tx_ready));
  // kind at a frame position: start, four lines, end
  function automatic logic [1:0] frame_kind(input logic [2:0] idx);
    if (idx == 3'h0) frame_kind = fwe_pkg::KIND_FS;
    else if (idx == 3'h5) frame_kind = fwe_pkg::KIND_FE;
    else frame_kind = fwe_pkg::KIND_LINE;
  endfunction
  // sources: whole packets always buffered, one to four words each
  always_comb for (int p = 0; p < 2; p++) begin
    avail[p] = src_on;
    bvalid[p] = src_on;
    last[p] = (w[p] == ln[p]);
    kind[p] = frame_kind((p == 0) ? pk[0] : 3'((pk[1] + k1_off) % 6));
    vc[p] = same_vc ? 2'h0 : 2'(p);
    bdata[p] = 32'({kind[p], 1'(p), w[p]});
  end
  // advance word index, draw a new length after each last word
  always @(posedge mclk) for (int p = 0; p < 2; p++) begin
    if (bvalid[p] && ready[p] && last[p]) begin
      w[p] <= #1 3'h0;
      ln[p] <= #1 3'($urandom % 4);
      pk[p] <= #1 (pk[p] == 3'h5) ? 3'h0 : pk[p] + 3'h1;
    end else if (bvalid[p] && ready[p]) begin
      w[p] <= #1 w[p] + 3'h1;
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // eight bits plus the ack slot, msb first
  task automatic b9(input logic [8:0] d);
    for (int i = 8; i >= 0; i--) begin
      sda_m = d[i];
      #100 scl = 1'b1;
      #100 r[i] = sda;
      #100 scl = 1'b0;
      #100;
    end
  endtask
  task automatic start();
    sda_m = 1'b1;
    #100 scl = 1'b1;
    #100 sda_m = 1'b0;
    #100 scl = 1'b0;
    #100;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #100 scl = 1'b1;
    #100 sda_m = 1'b1;
    #100;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    b9({fwe_pkg::I2C_ADDR_DEF, 2'b01});
    chk({7'h0, r[0]}, 8'h00, "address ack");
    b9({a, 1'b1});
    b9({d, 1'b1});
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    b9({fwe_pkg::I2C_ADDR_DEF, 2'b01});
    b9({a, 1'b1});
    start();
    b9({fwe_pkg::I2C_ADDR_DEF, 2'b11});
    b9(9'h1ff);
    d = r[8:1];
    stop();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog, nearly three times the expected run
  initial begin
    #1000000;
    fails++;
    results();
  end
  // main sequence
  initial begin
    void'($urandom(64));
    wait_c(4);
    resetn = 1'b1;
    wait_c(4);
    foreach (adr[i]) begin
      rd(adr[i], v);
      chk(v, rst[i], "register reset");
    end
    chk({7'h0, sda_out}, 8'h00, "open drain data");
    chk({7'h0, lp11}, 8'h00, "stop state while off");
    wr(fwe_pkg::ADR_TX_CTL, 8'h03);
    wait_c(10);
    chk({7'h0, lp11}, 8'h01, "stop state enabled");
    chk({7'h0, cont}, 8'h01, "continuous clock");
    wr(fwe_pkg::ADR_TX_CTL, 8'h01);
    src_on = 1'b1;
    wait_c(60);
    chk({7'h0, hs}, 8'h00, "idle burst");
    chk(8'(rx_u.vc_log.size()), 8'h00, "pull while disabled");
    wr(fwe_pkg::ADR_FWD_PORT, 8'h20);
    wait_c(300);
    chk({7'h0, rx_u.vc_log.size() > 0}, 8'h01, "port0 traffic");
    foreach (rx_u.vc_log[i]) chk({6'h0, rx_u.vc_log[i]}, 8'h00, "port1 held");
    wr(fwe_pkg::ADR_FWD_PORT, 8'h00);
    wait_c(100);
    rx_u.vc_log.delete();
    wait_c(400);
    chk({7'h0, rx_u.vc_log.size() > 4}, 8'h01, "both ports");
    for (int i = 1; i < rx_u.vc_log.size(); i++) begin
      chk({6'h0, rx_u.vc_log[i]}, {6'h0, rx_u.vc_log[i-1] ^ 2'h1}, "turn");
    end
    wr(fwe_pkg::ADR_FWD_MODE, 8'h00);
    wait_c(150);
    rx_u.vc_log.delete();
    wait_c(200);
    chk(8'(rx_u.vc_log.size()), 8'h00, "no mode");
    rd(fwe_pkg::ADR_TX_STATUS, v);
    chk({7'h0, v[fwe_pkg::STS_SYNC_BIT]}, 8'h00, "sync status");
    // basic synchronized forwarding
    wr(fwe_pkg::ADR_FWD_PORT, 8'h00);
    wr(fwe_pkg::ADR_FWD_MODE, 8'h04);
    wait_c(300);
    rx_u.vc_log.delete();
    rx_u.pk_log.delete();
    wait_c(300);
    chk({7'h0, rx_u.pk_log.size() > 4}, 8'h01, "synced traffic");
    for (int i = 1; i < rx_u.pk_log.size(); i++) begin
      chk({7'h0, rx_u.pk_log[i][0]}, {7'h0, ~rx_u.pk_log[i-1][0]}, "sync order");
      if (!rx_u.pk_log[i-1][0]) begin
        chk({6'h0, rx_u.pk_log[i][2:1]}, {6'h0, rx_u.pk_log[i-1][2:1]}, "pair kind");
      end
    end
    foreach (rx_u.vc_log[i]) begin
      chk({6'h0, rx_u.vc_log[i]}, {7'h0, rx_u.pk_log[i][0]}, "port channel");
    end
    rd(fwe_pkg::ADR_TX_STATUS, v);
    chk({6'h0, v[fwe_pkg::STS_LOST_BIT], v[fwe_pkg::STS_SYNC_BIT]}, 8'h01, "locked");
    // port1 slips a packet: loss, then relock at the next frame start
    k1_off = 3'h1;
    wait_c(150);
    rd(fwe_pkg::ADR_TX_STATUS, v);
    chk({7'h0, v[fwe_pkg::STS_LOST_BIT]}, 8'h01, "sync lost");
    rd(fwe_pkg::ADR_TX_STATUS, v);
    chk({6'h0, v[fwe_pkg::STS_LOST_BIT], v[fwe_pkg::STS_SYNC_BIT]}, 8'h01, "relocked");
    // line interleave on one shared channel
    same_vc = 1'b1;
    wr(fwe_pkg::ADR_FWD_MODE, 8'h08);
    wait_c(100);
    rx_u.vc_log.delete();
    rx_u.pk_log.delete();
    wait_c(300);
    foreach (rx_u.pk_log[i]) begin
      v = {5'h0, rx_u.pk_log[i]};
      n1 += v[0];
      chk({7'h0, v[0] && v[2:1] != fwe_pkg::KIND_LINE}, 8'h00, "port1 framing");
      chk({6'h0, rx_u.vc_log[i]}, 8'h00, "shared channel");
    end
    chk({7'h0, n1 > 2}, 8'h01, "port1 lines");
    // shutdown: forwarding off before the transmitter
    wr(fwe_pkg::ADR_FWD_PORT, fwe_pkg::RST_FWD_PORT);
    wait_c(150);
    wr(fwe_pkg::ADR_TX_CTL, fwe_pkg::RST_TX_CTL);
    chk({6'h0, lp11, hs}, 8'h00, "transmitter off");
    results();
  end
endmodule
